// file: src/bpo_core.sv
// bridge pwm output stage: timer, steering, dead band, shutdown
// assumes a plain register port and pins synchronised here
module bpo_core (
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       shutdown_pin_b_in,
  input  wire logic       comparator_shutdown_in,
  output logic            out_a_out,
  output logic            out_a_oe_out,
  output logic            out_b_out,
  output logic            out_b_oe_out,
  output logic            out_c_out,
  output logic            out_c_oe_out,
  output logic            out_d_out,
  output logic            out_d_oe_out,
  output logic            timer_period_flag_out
);
  typedef struct packed {
    logic            ext_s1;
    logic            ext_s2;
    logic            cmp_s1;
    logic            cmp_s2;
    logic [1:0]      omode;
    logic [1:0]      pwm_mode;
    logic [1:0]      pol;
    logic [2:0]      src_sel;
    logic [1:0]      st_ac;
    logic [1:0]      st_bd;
    logic            auto_rs;
    logic [6:0]      dbc;
    logic [3:0]      steer_reg;
    logic            steer_sync;
    logic [3:0]      steer_live;
    logic [7:0]      period;
    logic [7:0]      duty;
    logic [7:0]      presc;
    logic [7:0]      presc_cnt;
    logic [1:0]      tcy_cnt;
    logic [7:0]      timer;
    logic            active;
    logic            blank;
    logic            dir;
    logic            ase;
    logic            hold;
    logic            flag;
    logic [1:0][6:0] db_cnt;
    logic [1:0]      db_out;
    logic [3:0]      out;
    logic [3:0]      oe;
    logic [7:0]      rdata;
  } bpo_state_t;

  bpo_state_t q;
  bpo_state_t d;
  logic       mode_on;
  logic       tick;
  logic       pstart;
  logic       cond;
  logic       sd_w;
  logic       raw_w;
  logic       full_w;
  logic       half_w;
  logic       tcy_en;
  logic       wr_shdn;
  logic       wr_steer;

  // shutdown state of one pin pair as {level, drive}
  function automatic logic [1:0] shut_drive(input logic [1:0] st);
    return {st == bpo_pkg::SS_HIGH,
            (st == bpo_pkg::SS_LOW) || (st == bpo_pkg::SS_HIGH)};
  endfunction

  assign mode_on  = q.pwm_mode == bpo_pkg::PWM_ON;
  assign tick     = mode_on && (q.presc_cnt >= q.presc);
  assign pstart   = tick && (q.timer == q.period);
  assign full_w   = (q.omode == bpo_pkg::OM_FWD) ||
                    (q.omode == bpo_pkg::OM_REV);
  assign half_w   = q.omode == bpo_pkg::OM_HALF;
  assign raw_w    = q.timer < q.duty;
  assign tcy_en   = q.tcy_cnt == bpo_pkg::TCY_LAST;
  assign wr_shdn  = wr_in && (addr_in == bpo_pkg::ADDR_SHDN);
  assign wr_steer = wr_in && (addr_in == bpo_pkg::ADDR_STEER);
  // level sensitive source selection
  assign cond = (q.src_sel[bpo_pkg::SRC_EXT] && !q.ext_s2) ||
                (q.src_sel[bpo_pkg::SRC_CMP] && q.cmp_s2);
  // outputs held from the event until the restart period
  assign sd_w = cond || q.ase || q.hold;

  always_comb
  begin
    logic [3:0] en;
    logic [3:0] act;
    logic [3:0] lvl;
    logic [1:0] db_req;
    logic [1:0] st;
    logic [1:0] sdrv;
    logic       modq;
    en     = 4'h0;
    act    = 4'h0;
    lvl    = 4'h0;
    db_req = 2'h0;
    st     = 2'h0;
    sdrv   = 2'h0;
    modq   = raw_w && !q.blank;
    d = q;
    d.ext_s1  = shutdown_pin_b_in;
    d.ext_s2  = q.ext_s1;
    d.cmp_s1  = comparator_shutdown_in;
    d.cmp_s2  = q.cmp_s1;
    d.tcy_cnt = q.tcy_cnt + 2'h1;
    d.rdata   = 8'h00;

    // period timer with prescaler
    if (!mode_on)
    begin
      d.presc_cnt = 8'h00;
      d.timer     = 8'h00;
      d.active    = 1'b0;
      d.blank     = 1'b0;
    end
    else if (tick)
    begin
      d.presc_cnt = 8'h00;
      if (pstart)
      begin
        d.timer  = 8'h00;
        d.active = 1'b1;
      end
      else
      begin
        d.timer = q.timer + 8'h01;
      end
    end
    else
    begin
      d.presc_cnt = q.presc_cnt + 8'h01;
    end

    // direction swaps on entering the last timer step
    if (!full_w)
    begin
      d.dir = q.omode[1];
    end
    else if (mode_on && (d.timer == q.period) && (q.omode[1] != q.dir))
    begin
      d.dir   = q.omode[1];
      d.blank = 1'b1;
    end
    else if (pstart)
    begin
      d.blank = 1'b0;
    end

    // period flag, set beats clear
    if (wr_in && (addr_in == bpo_pkg::ADDR_STATUS) &&
        wdata_in[bpo_pkg::FLAG_BIT])
      d.flag = 1'b0;
    if (pstart)
      d.flag = 1'b1;

    // register writes
    if (wr_in)
    begin
      case (addr_in)
        bpo_pkg::ADDR_CTRL:
        begin
          d.omode    = wdata_in[bpo_pkg::OMODE_LSB +: 2];
          d.pwm_mode = wdata_in[bpo_pkg::PWMSEL_LSB +: 2];
          d.pol      = wdata_in[bpo_pkg::POL_LSB +: 2];
        end
        bpo_pkg::ADDR_SHDN:
        begin
          d.st_bd   = wdata_in[bpo_pkg::BD_LSB +: 2];
          d.st_ac   = wdata_in[bpo_pkg::AC_LSB +: 2];
          d.src_sel = wdata_in[bpo_pkg::SRC_LSB +: 3];
        end
        bpo_pkg::ADDR_DBAND:
        begin
          d.dbc     = wdata_in[bpo_pkg::DBC_LSB +: 7];
          d.auto_rs = wdata_in[bpo_pkg::RSEN_BIT];
        end
        bpo_pkg::ADDR_PERIOD: d.period = wdata_in;
        bpo_pkg::ADDR_DUTY:   d.duty = wdata_in;
        bpo_pkg::ADDR_PRESC:  d.presc = wdata_in;
        default: ;
      endcase
    end

    // event status
    if (q.auto_rs && q.ase && !cond)
      d.ase = 1'b0;
    if (wr_shdn && !cond)
      d.ase = wdata_in[bpo_pkg::ASE_BIT];
    if (cond)
      d.ase = 1'b1;
    if (cond || q.ase)
      d.hold = 1'b1;
    else if (pstart)
      d.hold = 1'b0;

    // steering update, immediate or at period start
    if (pstart && q.steer_sync)
      d.steer_live = q.steer_reg;
    if (wr_steer)
    begin
      d.steer_reg  = wdata_in[bpo_pkg::STR_LSB +: 4];
      d.steer_sync = wdata_in[bpo_pkg::SYNC_BIT];
      if (!wdata_in[bpo_pkg::SYNC_BIT])
      begin
        d.steer_live = wdata_in[bpo_pkg::STR_LSB +: 4];
      end
    end

    // dead band on each rising request, half bridge only
    db_req = (half_w && q.active) ? {!raw_w, raw_w} : 2'h0;
    for (int i = 0; i < 2; i++)
    begin
      if (!db_req[i])
      begin
        d.db_cnt[i] = 7'h00;
      end
      else if (tcy_en && (q.db_cnt[i] < q.dbc))
      begin
        d.db_cnt[i] = q.db_cnt[i] + 7'h01;
      end
      d.db_out[i] = db_req[i] && (q.db_cnt[i] >= q.dbc);
    end

    // pin enables and active levels, bit order d c b a
    case (q.omode)
      bpo_pkg::OM_SINGLE:
      begin
        en  = q.steer_live;
        act = {4{raw_w}};
      end
      bpo_pkg::OM_HALF:
      begin
        en  = 4'h3;
        act = {2'h0, q.db_out};
      end
      default:
      begin
        en  = 4'hF;
        act = q.dir ? {1'b0, 1'b1, modq, 1'b0}
                    : {modq, 1'b0, 1'b0, 1'b1};
      end
    endcase
    if (!mode_on)
      en = 4'h0;
    if (!q.active)
      act = 4'h0;
    // polarity per pair, steered pins included
    lvl = act ^ {q.pol[1], q.pol[0], q.pol[1], q.pol[0]};

    // shutdown only on enabled pins
    for (int i = 0; i < 4; i++)
    begin
      st   = (i % 2 == 0) ? q.st_ac : q.st_bd;
      sdrv = shut_drive(st);
      if (en[i] && sd_w)
      begin
        d.out[i] = sdrv[1];
        d.oe[i]  = sdrv[0];
      end
      else
      begin
        d.out[i] = en[i] && lvl[i];
        d.oe[i]  = en[i];
      end
    end

    // read data for the next cycle
    if (rd_in)
    begin
      case (addr_in)
        bpo_pkg::ADDR_CTRL:   d.rdata = {2'h0, q.pol, q.pwm_mode, q.omode};
        bpo_pkg::ADDR_SHDN:   d.rdata = {q.ase, q.src_sel, q.st_ac, q.st_bd};
        bpo_pkg::ADDR_DBAND:  d.rdata = {q.auto_rs, q.dbc};
        bpo_pkg::ADDR_STEER:  d.rdata = {3'h0, q.steer_sync, q.steer_reg};
        bpo_pkg::ADDR_PERIOD: d.rdata = q.period;
        bpo_pkg::ADDR_DUTY:   d.rdata = q.duty;
        bpo_pkg::ADDR_PRESC:  d.rdata = q.presc;
        bpo_pkg::ADDR_STATUS:
          d.rdata = {3'h0, q.active, q.hold, cond, q.dir, q.flag};
        default:              d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      q        <= '0;
      q.ext_s1 <= 1'b1;
      q.ext_s2 <= 1'b1;
      q.period <= bpo_pkg::RST_PERIOD;
      q.duty   <= bpo_pkg::RST_DUTY;
      q.presc  <= bpo_pkg::RST_PRESC;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata_out             = q.rdata;
  assign out_a_out             = q.out[0];
  assign out_a_oe_out          = q.oe[0];
  assign out_b_out             = q.out[1];
  assign out_b_oe_out          = q.oe[1];
  assign out_c_out             = q.out[2];
  assign out_c_oe_out          = q.oe[2];
  assign out_d_out             = q.out[3];
  assign out_d_oe_out          = q.oe[3];
  assign timer_period_flag_out = q.flag;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_ase_follows_cond: assert property (cond |=> q.ase)
    else $error("status not set by shutdown condition");
  a_ase_write_blocked: assert property (
    (cond && wr_shdn && !wdata_in[bpo_pkg::ASE_BIT]) |=> q.ase)
    else $error("status cleared while condition present");
  a_auto_restart_clr: assert property (
    (q.auto_rs && q.ase && !cond && !wr_shdn) |=> !q.ase)
    else $error("auto restart did not clear status");
  a_hold_until_period: assert property (
    (q.hold && !q.ase && !cond && !pstart) |=> q.hold)
    else $error("outputs released before period start");
  a_dir_in_last_step: assert property (
    (full_w && $changed(q.dir)) |-> (q.timer == q.period))
    else $error("direction changed outside last timer step");
  a_blank_ends_period: assert property (
    (q.blank && pstart) |=> !q.blank ##1 !q.blank)
    else $error("modulation not resumed at period start");
  a_full_no_deadband: assert property (
    (mode_on && q.omode == bpo_pkg::OM_FWD && q.active && !sd_w &&
     !q.blank && !q.dir) |=> (q.out[3] == ($past(raw_w) ^ q.pol[1]))
    and q.out[0] != q.pol[0])
    else $error("forward full bridge output wrong");
  a_deadband_holds: assert property (
    (half_w && q.db_cnt[0] < q.dbc) |=> !q.db_out[0])
    else $error("dead band released early");
  a_shutdown_low: assert property (
    (sd_w && mode_on && half_w && q.st_ac == bpo_pkg::SS_LOW)
    |=> (q.oe[0] && !q.out[0] && !q.oe[2]))
    else $error("pair shutdown state wrong");
  a_steer_now: assert property (
    (wr_steer && !wdata_in[bpo_pkg::SYNC_BIT])
    |=> q.steer_live == $past(wdata_in[3:0]))
    else $error("unsynced steering not applied");
  a_steer_waits: assert property (
    (q.steer_sync && !pstart && !wr_steer) |=> $stable(q.steer_live))
    else $error("synced steering applied mid period");

  c_shutdown_restart: cover property (q.hold ##1 !q.hold);
  c_dir_change: cover property (q.blank ##[1:300] !q.blank);
  c_steer_sync: cover property (q.steer_sync && pstart);
  c_deadband_out: cover property (half_w && q.dbc != 7'h00 && q.db_out[0]);
endmodule

// file: src/bpo_pkg.sv
// constants for the bridge pwm output stage
// assumes a single 100 MHz clock that also stands for the oscillator
package bpo_pkg;
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 8;
  // register offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_SHDN   = 4'h1;
  localparam logic [3:0] ADDR_DBAND  = 4'h2;
  localparam logic [3:0] ADDR_STEER  = 4'h3;
  localparam logic [3:0] ADDR_PERIOD = 4'h4;
  localparam logic [3:0] ADDR_DUTY   = 4'h5;
  localparam logic [3:0] ADDR_PRESC  = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  // field positions
  localparam int unsigned OMODE_LSB  = 0;
  localparam int unsigned PWMSEL_LSB = 2;
  localparam int unsigned POL_LSB    = 4;
  localparam int unsigned BD_LSB     = 0;
  localparam int unsigned AC_LSB     = 2;
  localparam int unsigned SRC_LSB    = 4;
  localparam int unsigned ASE_BIT    = 7;
  localparam int unsigned DBC_LSB    = 0;
  localparam int unsigned RSEN_BIT   = 7;
  localparam int unsigned STR_LSB    = 0;
  localparam int unsigned SYNC_BIT   = 4;
  localparam int unsigned FLAG_BIT   = 0;
  localparam int unsigned DIR_BIT    = 1;
  localparam int unsigned COND_BIT   = 2;
  localparam int unsigned HOLD_BIT   = 3;
  localparam int unsigned ACT_BIT    = 4;
  localparam int unsigned SRC_EXT    = 0;
  localparam int unsigned SRC_CMP    = 1;
  // values after reset
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_DUTY   = 8'h00;
  localparam logic [7:0] RST_PRESC  = 8'h00;
  // mode encodings
  localparam logic [1:0] OM_SINGLE = 2'h0;
  localparam logic [1:0] OM_FWD    = 2'h1;
  localparam logic [1:0] OM_HALF   = 2'h2;
  localparam logic [1:0] OM_REV    = 2'h3;
  localparam logic [1:0] PWM_ON    = 2'h3;
  localparam logic [1:0] SS_LOW    = 2'h0;
  localparam logic [1:0] SS_HIGH   = 2'h1;
  // instruction cycle is four oscillator periods
  localparam int unsigned TOSC_PER_TCY = 4;
  localparam logic [1:0]  TCY_LAST     = 2'(TOSC_PER_TCY - 1);
endpackage

// file: testbench/bpo_switch_model.sv
// power switch driver model on the four bridge pins
// assumes pull-downs on the pins; trips are commanded by the bench
module bpo_switch_model (
  input  wire logic [3:0] pin_in,
  input  wire logic [3:0] oe_in,
  input  wire logic       trip_ext_in,
  input  wire logic       trip_cmp_in,
  output logic      [3:0] pad_out,
  output logic            shutdown_pin_b_out,
  output logic            comparator_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pins fall to the pull-down level
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pad_out[i] = oe_in[i] ? pin_in[i] : 1'b0;
  end
  // trip lines are levels held as long as the fault lasts
  assign shutdown_pin_b_out = ~trip_ext_in;
  assign comparator_out     = trip_cmp_in;
endmodule

// file: testbench/bridge_pwm_output_control_bench.sv
// self-checking bench for the bridge pwm output stage
// assumes bpo_core and the switch model; 100 MHz clock
module bridge_pwm_output_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_in  = 1'b0;
  logic       rst_b_in = 1'b0;
  logic [3:0] addr     = 4'h0;
  logic [7:0] wdata    = 8'h00;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  logic       trip_ext = 1'b0;
  logic       trip_cmp = 1'b0;
  logic [7:0] rdata;
  logic [3:0] pin;
  logic [3:0] oe;
  logic [3:0] pad;
  logic       sd_b;
  logic       cmp;
  logic       flag;
  int         error_cnt   = 0;
  int         checks_done = 0;
  int         cnt [4];
  int         duty;
  int         modes [3] = '{2, 1, 3};

  always #5 mclk_in = ~mclk_in;

  bpo_core dut (
    .mclk_in                (mclk_in),
    .rst_b_in               (rst_b_in),
    .addr_in                (addr),
    .wdata_in               (wdata),
    .wr_in                  (wr),
    .rd_in                  (rd),
    .rdata_out              (rdata),
    .shutdown_pin_b_in      (sd_b),
    .comparator_shutdown_in (cmp),
    .out_a_out              (pin[0]),
    .out_a_oe_out           (oe[0]),
    .out_b_out              (pin[1]),
    .out_b_oe_out           (oe[1]),
    .out_c_out              (pin[2]),
    .out_c_oe_out           (oe[2]),
    .out_d_out              (pin[3]),
    .out_d_oe_out           (oe[3]),
    .timer_period_flag_out  (flag)
  );

  bpo_switch_model far_side (
    .pin_in             (pin),
    .oe_in              (oe),
    .trip_ext_in        (trip_ext),
    .trip_cmp_in        (trip_cmp),
    .pad_out            (pad),
    .shutdown_pin_b_out (sd_b),
    .comparator_out     (cmp)
  );

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_in);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_in);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    chk(v, e);
  endtask

  task automatic trip(input logic e, input logic c);
    @(posedge mclk_in);
    trip_ext <= e;
    trip_cmp <= c;
    repeat (8) @(posedge mclk_in);
  endtask

  // high cycles of each pad over one period of eight clocks
  task automatic chk_cnt(input int a, input int b, input int c,
                         input int d);
    cnt = '{0, 0, 0, 0};
    repeat (8)
    begin
      @(negedge mclk_in);
      for (int i = 0; i < 4; i++)
        cnt[i] += int'(pad[i] === 1'b1);
    end
    chk(8'(cnt[0]), 8'(a));
    chk(8'(cnt[1]), 8'(b));
    chk(8'(cnt[2]), 8'(c));
    chk(8'(cnt[3]), 8'(d));
  endtask

  task automatic wait_flag();
    int         n;
    logic [7:0] v;
    n = 0;
    do
    begin
      rd_reg(bpo_pkg::ADDR_STATUS, v);
      n++;
    end
    while (v[bpo_pkg::FLAG_BIT] !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic wait_rise();
    int n;
    n = 0;
    while (pad[0] !== 1'b0 && n < 20)
    begin
      @(negedge mclk_in);
      n++;
    end
    while (pad[0] !== 1'b1 && n < 40)
    begin
      @(negedge mclk_in);
      n++;
    end
    if (n >= 40)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  // full bridge holds one pin, modulates one; long dead band blanks
  function automatic int exp_cnt(input int mode, input int p);
    case (mode)
      1: return p == 0 ? 8 : (p == 3 ? duty : 0);
      3: return p == 2 ? 8 : (p == 1 ? duty : 0);
      default: return 0;
    endcase
  endfunction

  initial
  begin
    void'($urandom(32'h9179));
    repeat (5) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rd_chk(bpo_pkg::ADDR_PERIOD, 8'hFF);
    rd_chk(bpo_pkg::ADDR_PRESC, 8'h00);
    rd_chk(bpo_pkg::ADDR_SHDN, 8'h00);
    rd_chk(4'h8, 8'h00);
    duty = 1 + int'($urandom % 6);
    wr_reg(bpo_pkg::ADDR_PERIOD, 8'h07);
    wr_reg(bpo_pkg::ADDR_DUTY, 8'(duty));
    wr_reg(bpo_pkg::ADDR_STEER, 8'h05);
    wr_reg(bpo_pkg::ADDR_CTRL, 8'h0C);
    wait_flag();
    chk(8'(flag), 8'h01);
    for (int p = 1; p >= 0; p--)
    begin
      wr_reg(bpo_pkg::ADDR_STEER, 8'h00);
      wr_reg(bpo_pkg::ADDR_CTRL, 8'(8'h0C | (p << 4)));
      wr_reg(bpo_pkg::ADDR_STEER, 8'h05);
      repeat (20) @(posedge mclk_in);
      chk_cnt(p ? 8 - duty : duty, 0, p ? 8 - duty : duty, 0);
    end
    wr_reg(bpo_pkg::ADDR_STEER, 8'h01);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(8'(oe), 8'h01);
    wait_rise();
    wr_reg(bpo_pkg::ADDR_STEER, 8'h15);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(8'(oe), 8'h01);
    repeat (10) @(posedge mclk_in);
    #1;
    chk(8'(oe), 8'h05);
    wr_reg(bpo_pkg::ADDR_SHDN, 8'h14);
    trip(1'b1, 1'b0);
    chk_cnt(8, 0, 8, 0);
    rd_chk(bpo_pkg::ADDR_SHDN, 8'h94);
    wr_reg(bpo_pkg::ADDR_SHDN, 8'h14);
    rd_chk(bpo_pkg::ADDR_SHDN, 8'h94);
    trip(1'b0, 1'b0);
    rd_chk(bpo_pkg::ADDR_SHDN, 8'h94);
    wr_reg(bpo_pkg::ADDR_SHDN, 8'h14);
    rd_chk(bpo_pkg::ADDR_SHDN, 8'h14);
    repeat (16) @(posedge mclk_in);
    chk_cnt(duty, 0, duty, 0);
    wr_reg(bpo_pkg::ADDR_DBAND, 8'h80);
    wr_reg(bpo_pkg::ADDR_SHDN, 8'h24);
    trip(1'b0, 1'b1);
    rd_chk(bpo_pkg::ADDR_SHDN, 8'hA4);
    trip(1'b0, 1'b0);
    rd_chk(bpo_pkg::ADDR_SHDN, 8'h24);
    repeat (16) @(posedge mclk_in);
    chk_cnt(duty, 0, duty, 0);
    wr_reg(bpo_pkg::ADDR_SHDN, 8'h00);
    wr_reg(bpo_pkg::ADDR_DBAND, 8'h03);
    foreach (modes[i])
    begin
      wr_reg(bpo_pkg::ADDR_CTRL, 8'(8'h0C | modes[i]));
      repeat (20) @(posedge mclk_in);
      chk_cnt(exp_cnt(modes[i], 0), exp_cnt(modes[i], 1),
              exp_cnt(modes[i], 2),
              exp_cnt(modes[i], 3));
    end
    wr_reg(bpo_pkg::ADDR_DBAND, 8'h00);
    wr_reg(bpo_pkg::ADDR_CTRL, 8'h0E);
    repeat (20) @(posedge mclk_in);
    chk_cnt(duty, 8 - duty, 0, 0);
    wr_reg(bpo_pkg::ADDR_SHDN, 8'h82);
    repeat (4) @(posedge mclk_in);
    #1;
    chk(8'({oe, pad}), 8'h10);
    rd_chk(bpo_pkg::ADDR_SHDN, 8'h82);
    wr_reg(bpo_pkg::ADDR_SHDN, 8'h02);
    repeat (16) @(posedge mclk_in);
    chk_cnt(duty, 8 - duty, 0, 0);
    report_and_stop();
  end
endmodule
